// file: hdl/ulsmc_top.sv
// Line status reporting, receive FIFO flags and modem control register
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module ulsmc_top
  import ulsmc_pkg::*;
(
  input  wire logic              CLOCK_IN,
  input  wire logic              RST_IN,
  input  wire logic              REG_RD_IN,
  input  wire logic              REG_WR_IN,
  input  wire logic              REG_SEL_IN,
  input  wire logic [7:0]        REG_WDATA_IN,
  output logic      [7:0]        REG_RDATA_OUT,
  input  wire logic              EFR_WE_IN,
  input  wire logic              RX_PUSH_IN,
  input  wire logic [DATA_W-1:0] RX_DATA_IN,
  input  wire logic              RX_BREAK_IN,
  input  wire logic              RX_FRAMING_IN,
  input  wire logic              RX_PARITY_IN,
  input  wire logic              RX_POP_IN,
  output logic      [DATA_W-1:0] RX_DATA_OUT,
  input  wire logic              TX_HOLD_EMPTY_IN,
  input  wire logic              TX_SHIFT_EMPTY_IN,
  input  wire logic              TX_SERIAL_IN,
  output logic                   TX_PIN_OUT,
  input  wire logic              RX_PIN_IN,
  output logic                   RX_LINE_OUT,
  input  wire logic              CTS_N_IN,
  input  wire logic              DSR_N_IN,
  output logic                   MS_CTS_OUT,
  output logic                   MS_DSR_OUT,
  output logic                   BAUD_EN_OUT,
  output logic                   IRDA_MODE_OUT,
  output logic                   XON_ANY_OUT,
  output logic                   TRIG_ACCESS_OUT,
  input  wire logic              AUTO_RTS_EN_IN,
  input  wire logic              AUTO_RTS_N_IN,
  output logic                   RTS_N_OUT,
  input  wire logic              DTR_SELECT_IN,
  input  wire logic              GENERAL_PIN_FIVE_LEVEL_IN,
  output logic                   GENERAL_PIN_FIVE_N_OUT
);

//////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  logic [2:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  always_comb begin
    sync1_next = {RX_PIN_IN, CTS_N_IN, DSR_N_IN};
    sync2_next = sync1_reg;
  end
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

//////////////////////////////////////////////////////////////////////////////
  // modem_control register
  logic [7:0] mc_reg, mc_next;
  always_comb begin
    mc_next = mc_reg;
    if (REG_WR_IN && REG_SEL_IN == SEL_MODEM_CONTROL) begin
      if (EFR_WE_IN)
        mc_next = REG_WDATA_IN;
      else
        mc_next = (mc_reg & MC_PROTECT_MASK) |
                  (REG_WDATA_IN & ~MC_PROTECT_MASK);
    end
  end
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) mc_reg <= MC_RESET_VAL;
    else        mc_reg <= mc_next;
  end

  logic loop_en;
  assign loop_en         = mc_reg[MC_LOOPBACK];
  assign IRDA_MODE_OUT   = mc_reg[MC_IRDA];
  assign XON_ANY_OUT     = mc_reg[MC_XON_ANY];
  assign TRIG_ACCESS_OUT = mc_reg[MC_TRIG_EN];
  // Line stays idle high while looped so the peer sees nothing
  assign TX_PIN_OUT  = loop_en ? 1'b1 : TX_SERIAL_IN;
  assign RX_LINE_OUT = loop_en ? TX_SERIAL_IN : sync2_reg[2];
  assign MS_CTS_OUT  = loop_en ? mc_reg[MC_RTS] : ~sync2_reg[1];
  assign MS_DSR_OUT  = loop_en ? mc_reg[MC_DTR] : ~sync2_reg[0];
  assign RTS_N_OUT   = AUTO_RTS_EN_IN ? AUTO_RTS_N_IN
                                      : ~mc_reg[MC_RTS];
  // Pin level register is ignored while the pin serves terminal-ready
  assign GENERAL_PIN_FIVE_N_OUT = DTR_SELECT_IN ? ~mc_reg[MC_DTR]
                                     : GENERAL_PIN_FIVE_LEVEL_IN;

//////////////////////////////////////////////////////////////////////////////
  // Prescaler: every cycle, or one in four
  logic [1:0] pre_reg, pre_next;
  always_comb begin
    pre_next = pre_reg + 2'h1;
    if (!mc_reg[MC_CLK_DIV4]) pre_next = 2'h0;
  end
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) pre_reg <= 2'h0;
    else        pre_reg <= pre_next;
  end
  assign BAUD_EN_OUT = !mc_reg[MC_CLK_DIV4] ||
                       (pre_reg == PRESCALE_LAST);

//////////////////////////////////////////////////////////////////////////////
  // Receive FIFO with per-character error flags
  logic [ENT_W-1:0]  mem_reg [FIFO_DEPTH];
  logic [ENT_W-1:0]  mem_next[FIFO_DEPTH];
  logic [PTR_W-1:0]  wp_reg, wp_next, rp_reg, rp_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next, err_reg, err_next;
  logic              ovr_reg, ovr_next;
  logic [DATA_W-1:0] rxd_reg, rxd_next;
  logic              do_push, do_pop, push_err, head_err;
  logic              ls_read;
  logic [ENT_W-1:0]  head;

  assign head     = mem_reg[rp_reg];
  assign do_pop   = RX_POP_IN && cnt_reg != '0;
  // A pop in the same cycle frees the slot, so a full FIFO still accepts
  assign do_push  = RX_PUSH_IN &&
                    (cnt_reg != CNT_W'(FIFO_DEPTH) || do_pop);
  assign push_err = RX_BREAK_IN | RX_FRAMING_IN | RX_PARITY_IN;
  assign head_err = |head[ENT_W-1:DATA_W];
  assign ls_read  = REG_RD_IN && REG_SEL_IN == SEL_LINE_STATUS;

  always_comb begin
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    err_next = err_reg;
    rxd_next = rxd_reg;
    ovr_next = ovr_reg;
    if (ls_read) ovr_next = 1'b0;
    if (RX_PUSH_IN && !do_push) ovr_next = 1'b1;
    if (do_push) begin
      mem_next[wp_reg] = {RX_BREAK_IN, RX_FRAMING_IN, RX_PARITY_IN,
                          RX_BREAK_IN ? BREAK_CHAR : RX_DATA_IN};
      wp_next = wp_reg + PTR_W'(1);
    end
    if (do_pop) begin
      rxd_next = head[DATA_W-1:0];
      rp_next  = rp_reg + PTR_W'(1);
    end
    cnt_next = cnt_reg + CNT_W'(do_push) - CNT_W'(do_pop);
    err_next = err_reg + CNT_W'(do_push && push_err)
                       - CNT_W'(do_pop && head_err);
  end
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
      err_reg <= '0;
      ovr_reg <= 1'b0;
      rxd_reg <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) mem_reg[i] <= '0;
    end else begin
      wp_reg   <= wp_next;
      rp_reg   <= rp_next;
      cnt_reg  <= cnt_next;
      err_reg  <= err_next;
      ovr_reg  <= ovr_next;
      rxd_reg  <= rxd_next;
      mem_reg  <= mem_next;
    end
  end
  assign RX_DATA_OUT = rxd_reg;

//////////////////////////////////////////////////////////////////////////////
  // Status word and read data
  logic [7:0] ls_val, rd_reg, rd_next;
  logic       not_empty;
  assign not_empty = cnt_reg != '0;
  always_comb begin
    ls_val               = 8'h00;
    ls_val[LS_FIFO_ERR]  = err_reg != '0;
    ls_val[LS_TX_EMPTY]  = TX_HOLD_EMPTY_IN & TX_SHIFT_EMPTY_IN;
    ls_val[LS_THR_EMPTY] = TX_HOLD_EMPTY_IN;
    // Empty FIFO holds stale flags, so they are masked
    ls_val[LS_BREAK]     = not_empty & head[ENT_W-1];
    ls_val[LS_FRAMING]   = not_empty & head[ENT_W-2];
    ls_val[LS_PARITY]    = not_empty & head[ENT_W-3];
    ls_val[LS_OVERRUN]   = ovr_reg;
    ls_val[LS_DATA_RDY]  = not_empty;
    rd_next = rd_reg;
    if (REG_RD_IN)
      rd_next = (REG_SEL_IN == SEL_LINE_STATUS) ? ls_val : mc_reg;
  end
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) rd_reg <= 8'h00;
    else        rd_reg <= rd_next;
  end
  assign REG_RDATA_OUT = rd_reg;

//////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_ls_read;
    REG_RD_IN && REG_SEL_IN == SEL_LINE_STATUS;
  endsequence
  sequence s_overflow;
    RX_PUSH_IN && !RX_POP_IN && cnt_reg == CNT_W'(FIFO_DEPTH);
  endsequence

  AST_FIFO_ERR: assert property (
    s_ls_read |=> REG_RDATA_OUT[LS_FIFO_ERR] == ($past(err_reg) != 0))
    else $error("fifo error flag mismatch");
  AST_TX_EMPTY: assert property (
    s_ls_read |=> REG_RDATA_OUT[LS_TX_EMPTY] ==
      $past(TX_HOLD_EMPTY_IN && TX_SHIFT_EMPTY_IN))
    else $error("transmit empty flag mismatch");
  AST_BREAK_ZERO: assert property (
    do_pop && head[ENT_W-1] |=> RX_DATA_OUT == BREAK_CHAR)
    else $error("break character not zero");
  AST_OVERRUN: assert property (
    s_overflow |=> ovr_reg)
    else $error("overrun not flagged");
  // A refused push in the same cycle wins over the clearing read
  AST_OVR_CLR: assert property (
    ls_read && !(RX_PUSH_IN && !do_push) |=> !ovr_reg)
    else $error("overrun not cleared by read");
  AST_DATA_RDY: assert property (
    RX_PUSH_IN && cnt_reg == 0 |=> ls_val[LS_DATA_RDY])
    else $error("data ready missing after push");
  AST_WRITE_LOCK: assert property (
    REG_WR_IN && REG_SEL_IN == SEL_MODEM_CONTROL && !EFR_WE_IN
      |=> (mc_reg & MC_PROTECT_MASK) ==
          ($past(mc_reg) & MC_PROTECT_MASK))
    else $error("protected bits changed");
  // Leaving divide-by-four mid-period gives the enable back at once
  AST_DIV4: assert property (
    mc_reg[MC_CLK_DIV4] && $stable(mc_reg) && BAUD_EN_OUT
      |=> (!BAUD_EN_OUT || !mc_reg[MC_CLK_DIV4]) [*3])
    else $error("prescaler too fast");
  AST_LOOP_CTS: assert property (
    loop_en |-> MS_CTS_OUT == mc_reg[MC_RTS] && TX_PIN_OUT)
    else $error("loopback routing wrong");
  AST_RTS: assert property (
    !AUTO_RTS_EN_IN |-> RTS_N_OUT == !mc_reg[MC_RTS])
    else $error("request-to-send level wrong");

  // Status word as the host sees it one cycle after the read
  AST_THR_EMPTY: assert property (
    s_ls_read |=> REG_RDATA_OUT[LS_THR_EMPTY] == $past(TX_HOLD_EMPTY_IN))
    else $error("holding empty flag mismatch");
  AST_HEAD_FLAGS: assert property (
    s_ls_read && cnt_reg != 0
      |=> REG_RDATA_OUT[LS_BREAK:LS_PARITY] == $past(head[ENT_W-1:DATA_W]))
    else $error("head flags mismatch");
  AST_EMPTY_FLAGS: assert property (
    s_ls_read && cnt_reg == 0
      |=> REG_RDATA_OUT[LS_BREAK:LS_PARITY] == 3'h0)
    else $error("flags of empty fifo not zero");
  AST_RDY_READ: assert property (
    s_ls_read |=> REG_RDATA_OUT[LS_DATA_RDY] == ($past(cnt_reg) != 0))
    else $error("data ready flag mismatch");

  // An errored character into an empty FIFO must raise the error flag
  sequence s_err_into_empty;
    RX_PUSH_IN && push_err && cnt_reg == 0;
  endsequence
  AST_ERR_SET: assert property (
    s_err_into_empty |=> ls_val[LS_FIFO_ERR] && ls_val[LS_DATA_RDY])
    else $error("fifo error flag not set");

  AST_OPEN_BITS: assert property (
    REG_WR_IN && REG_SEL_IN == SEL_MODEM_CONTROL
      |=> (mc_reg & ~MC_PROTECT_MASK) ==
          ($past(REG_WDATA_IN) & ~MC_PROTECT_MASK))
    else $error("open control bits not written");
  AST_DIV1: assert property (
    !mc_reg[MC_CLK_DIV4] |-> BAUD_EN_OUT)
    else $error("undivided clock enable missing");
  AST_LOOP_RX: assert property (
    loop_en |-> RX_LINE_OUT == TX_SERIAL_IN)
    else $error("loopback receive path wrong");
  AST_DTR: assert property (
    DTR_SELECT_IN |-> GENERAL_PIN_FIVE_N_OUT == !mc_reg[MC_DTR])
    else $error("terminal-ready level wrong");
  AST_MODES: assert property (
    IRDA_MODE_OUT == mc_reg[MC_IRDA] && XON_ANY_OUT == mc_reg[MC_XON_ANY])
    else $error("mode outputs do not follow control bits");
endmodule

// file: hdl/ulsmc_pkg.sv
// Constants for the line status and modem control block
package ulsmc_pkg;
  localparam int FIFO_DEPTH  = 64;
  localparam int PTR_W       = 6;
  localparam int CNT_W       = 7;
  localparam int DATA_W      = 8;
  // Register select codes on the register port
  localparam logic SEL_LINE_STATUS   = 1'b0;
  localparam logic SEL_MODEM_CONTROL = 1'b1;
  // line_status bit positions
  localparam int LS_FIFO_ERR  = 7;
  localparam int LS_TX_EMPTY  = 6;
  localparam int LS_THR_EMPTY = 5;
  localparam int LS_BREAK     = 4;
  localparam int LS_FRAMING   = 3;
  localparam int LS_PARITY    = 2;
  localparam int LS_OVERRUN   = 1;
  localparam int LS_DATA_RDY  = 0;
  // modem_control bit positions
  localparam int MC_CLK_DIV4  = 7;
  localparam int MC_IRDA      = 6;
  localparam int MC_XON_ANY   = 5;
  localparam int MC_LOOPBACK  = 4;
  localparam int MC_TRIG_EN   = 2;
  localparam int MC_RTS       = 1;
  localparam int MC_DTR       = 0;
  // Bits guarded by the enhanced feature write enable
  localparam logic [7:0] MC_PROTECT_MASK = 8'he4;
  localparam logic [7:0] MC_RESET_VAL    = 8'h00;
  localparam logic [7:0] BREAK_CHAR      = 8'h00;
  localparam logic [1:0] PRESCALE_LAST   = 2'h3;
  // Entry layout: {break, framing, parity, data}
  localparam int ENT_W = DATA_W + 3;
endpackage

// file: tb/ulsmc_peer.sv
// Remote serial peer: echoes the line and drives the modem inputs
`timescale 1ns/10ps
module ulsmc_peer (
  input  wire logic clk_in,
  input  wire logic tx_pin_in,
  input  wire logic cts_want_in,
  input  wire logic dsr_want_in,
  output logic      rx_pin_out,
  output logic      cts_n_out,
  output logic      dsr_n_out
);
  // Echo one cycle late, as a cable would loop back
  always_ff @(posedge clk_in) begin
    rx_pin_out <= tx_pin_in;
  end
  assign cts_n_out = ~cts_want_in;
  assign dsr_n_out = ~dsr_want_in;
endmodule

// file: tb/tb_ulsmc_top.sv
// Self-checking bench for the line status and modem control block
`timescale 1ns/10ps
module tb_ulsmc_top import ulsmc_pkg::*; ;
  logic clk, rst, rd, wr, sel, enhanced_feature_reg, push, brk, fe, pe, pop, the, tse;
  logic txs, txp, rxp, rxl, ctsn, dsrn, mcts, mdsr, baud, irda, xon;
  logic trig, aen, artsn, rtsn, dsel, glev, gn, wc, wd, ov;
  logic [7:0] wdata, rdata, rxd, rxo, s, v, mc, r;
  logic [10:0] q[$];
  int fail_count, checked, n;
  always #2.5 clk = ~clk;
  ulsmc_peer i_ulsmc_peer (.clk_in(clk), .tx_pin_in(txp),
    .cts_want_in(wc), .dsr_want_in(wd), .rx_pin_out(rxp),
    .cts_n_out(ctsn), .dsr_n_out(dsrn));
  ulsmc_top i_ulsmc_top (.CLOCK_IN(clk), .RST_IN(rst), .REG_RD_IN(rd),
    .REG_WR_IN(wr), .REG_SEL_IN(sel), .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata), .EFR_WE_IN(enhanced_feature_reg), .RX_PUSH_IN(push),
    .RX_DATA_IN(rxd), .RX_BREAK_IN(brk), .RX_FRAMING_IN(fe),
    .RX_PARITY_IN(pe), .RX_POP_IN(pop), .RX_DATA_OUT(rxo),
    .TX_HOLD_EMPTY_IN(the), .TX_SHIFT_EMPTY_IN(tse),
    .TX_SERIAL_IN(txs), .TX_PIN_OUT(txp), .RX_PIN_IN(rxp),
    .RX_LINE_OUT(rxl), .CTS_N_IN(ctsn), .DSR_N_IN(dsrn),
    .MS_CTS_OUT(mcts), .MS_DSR_OUT(mdsr), .BAUD_EN_OUT(baud),
    .IRDA_MODE_OUT(irda), .XON_ANY_OUT(xon), .TRIG_ACCESS_OUT(trig),
    .AUTO_RTS_EN_IN(aen), .AUTO_RTS_N_IN(artsn), .RTS_N_OUT(rtsn),
    .DTR_SELECT_IN(dsel), .GENERAL_PIN_FIVE_LEVEL_IN(glev), .GENERAL_PIN_FIVE_N_OUT(gn));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [7:0] exp_ls();
    logic e;
    logic [2:0] h;
    e = 1'b0;
    foreach (q[i]) e |= |q[i][10:8];
    h = (q.size() != 0) ? q[0][10:8] : 3'h0;
    return {e, the & tse, the, h, ov, q.size() != 0};
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic rdreg(input logic rs, output logic [7:0] d);
    rd = 1'b1;
    sel = rs;
    step();
    rd = 1'b0;
    d = rdata;
    // Status read clears the overrun flag
    if (!rs) ov = 1'b0;
    step();
  endtask
  task automatic wrreg(input logic [7:0] val);
    wr = 1'b1;
    sel = 1'b1;
    wdata = val;
    step();
    wr = 1'b0;
    mc = enhanced_feature_reg ? val : (mc & MC_PROTECT_MASK) | (val & ~MC_PROTECT_MASK);
    step();
  endtask
  task automatic rxpush(input logic [7:0] d, input logic [2:0] f);
    push = 1'b1;
    rxd = d;
    {brk, fe, pe} = f;
    step();
    push = 1'b0;
    if (q.size() < FIFO_DEPTH) q.push_back({f, f[2] ? BREAK_CHAR : d});
    else ov = 1'b1;
    step();
  endtask
  task automatic rxpop();
    logic [10:0] e;
    pop = 1'b1;
    step();
    pop = 1'b0;
    e = q.pop_front();
    chk(rxo, e[7:0]);
    step();
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  initial begin
    {clk, rd, wr, sel, enhanced_feature_reg, push, brk, fe, pe, pop, the, tse} = '0;
    {txs, aen, artsn, dsel, glev, wc, wd, ov} = '0;
    {wdata, rxd} = '0;
    mc = MC_RESET_VAL;
    s = 8'h5c;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    rdreg(1'b1, v);
    chk(v, MC_RESET_VAL);
    chk(8'({rtsn, baud}), 8'h03);
    wrreg(8'hff);
    rdreg(1'b1, v);
    chk(v, mc);
    // Random control writes; modem inputs settle through two sync flops
    repeat (16) begin
      s = nxt(s);
      {enhanced_feature_reg, aen, artsn, dsel, glev, txs, wc, wd} = s;
      s = nxt(s);
      wrreg(s);
      repeat (3) step();
      rdreg(1'b1, v);
      chk(v, mc);
      chk(8'({irda, xon, trig}), 8'({mc[6], mc[5], mc[2]}));
      chk(8'(rtsn), 8'(aen ? artsn : !mc[1]));
      chk(8'(gn), 8'(dsel ? !mc[0] : glev));
      chk(8'({mcts, mdsr}), 8'(mc[4] ? mc[1:0] : {wc, wd}));
      chk(8'({txp, rxl}), 8'(mc[4] ? {1'b1, txs} : {txs, rxp}));
    end
    enhanced_feature_reg = 1'b1;
    wrreg(8'h80);
    n = 0;
    repeat (40) begin
      n += int'(baud);
      step();
    end
    chk(8'(n), 8'h0a);
    wrreg(8'h00);
    chk(8'(baud), 8'h01);
    // Fill past depth to force overruns, then drain past empty
    repeat (FIFO_DEPTH + 4) begin
      s = nxt(s);
      {the, tse} = s[1:0];
      rxpush(s, {s[7] & s[6], s[5] & s[4], s[3] & s[2]});
      // Nothing popped yet, so the character output keeps its reset value
      chk(rxo, 8'h00);
      v = exp_ls();
      rdreg(1'b0, r);
      chk(r, v);
    end
    while (q.size() != 0) begin
      v = exp_ls();
      rdreg(1'b0, r);
      chk(r, v);
      rxpop();
    end
    // A pop of an empty FIFO must leave the last character standing
    v = rxo;
    pop = 1'b1;
    step();
    pop = 1'b0;
    step();
    chk(rxo, v);
    rdreg(1'b0, r);
    chk(r, exp_ls());
    end_of_test();
  end
endmodule
